// [hdl/fault_dispatch_pkg.sv]
// constants, offsets and types shared by the fault dispatch unit
// Contract
// - interrupt first, fault info in record
// - or select handler, then interrupt
// - fault type indexes one table entry
// - table base from memory image, anywhere (the code takes it from the OFF_FT_BASE register)
// - two-word entries, entry-type field decides
// - type 00 means local extended call
// - type 10 means system procedure call
// - local, local table, supervisor paths
// - restore process controls only in supervisor
// - local returns resume at saved address
// - save return address into r2 slot
// - local return ignores resumption record
// - arithmetic mask bits suppress their faults
// - no-imprecise flag governs imprecise synchronising
// - trace modes select, trace enable gates
// - user to supervisor: local records, stack switch
package fault_dispatch_pkg;

  localparam int          AW            = 32;
  localparam int          STAT_W        = 4;
  // register byte offsets
  localparam logic [11:0] OFF_FT_BASE   = 12'h000;
  localparam logic [11:0] OFF_SPT_BASE  = 12'h004;
  localparam logic [11:0] OFF_ARITH     = 12'h008;
  localparam logic [11:0] OFF_TRACE     = 12'h00C;
  localparam logic [11:0] OFF_PROC      = 12'h010;
  localparam logic [11:0] OFF_STATUS    = 12'h014;
  localparam logic [11:0] OFF_MASK      = 12'h018;
  localparam logic [11:0] OFF_STATE     = 12'h01C;
  // arithmetic control fields
  localparam int          AC_INT_OVF    = 0;
  localparam int          AC_FP_LSB     = 1;
  localparam int          FP_MASKED_N   = 5;
  localparam int          AC_NIF        = 15;
  localparam logic [15:0] ARITH_RST     = 16'h0000;
  // process control fields
  localparam int          PC_TRACE_EN   = 0;
  localparam int          PC_POLICY     = 1;
  // status bits
  localparam int          ST_DISPATCH   = 0;
  localparam int          ST_SUPPRESS   = 1;
  localparam int          ST_BAD_ENTRY  = 2;
  localparam int          ST_RETURN     = 3;
  // fault type numbers and subtypes
  localparam logic [7:0]  FT_TRACE      = 8'h01;
  localparam logic [7:0]  FT_ARITH      = 8'h03;
  localparam logic [7:0]  FT_FLOAT      = 8'h04;
  localparam logic [7:0]  SUB_INT_OVF   = 8'h01;
  // fault table entries
  localparam int          ENTRY_SHIFT   = 3;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
  localparam logic [1:0]  ET_LOCAL      = 2'h0;
  localparam logic [1:0]  ET_SYSTEM     = 2'h2;
  localparam logic [1:0]  SPT_SUPER     = 2'h2;
  // system procedure table layout
  localparam logic [31:0] SPT_SSP_OFF   = 32'h0000_000C;
  localparam logic [31:0] SPT_ENTRY_OFF = 32'h0000_0030;

  typedef enum logic [1:0] {CALL_LOCAL, CALL_LOCAL_TABLE, CALL_SUPER} call_kind_t;

endpackage

// [hdl/fault_filter.sv]
// decides whether a raised fault condition is signalled or suppressed
`timescale 1ns/1ps
module fault_filter (
  input  wire logic [7:0]  fault_type,
  input  wire logic [7:0]  fault_subtype,
  input  wire logic [15:0] arith_ctrl,
  input  wire logic [7:0]  trace_modes,
  input  wire logic        trace_en,
  output logic             suppress
);
  import fault_dispatch_pkg::*;

  logic [fault_dispatch_pkg::FP_MASKED_N-1:0] fp_live;

  genvar i;
  generate
    for (i = 0; i < FP_MASKED_N; i++) begin : g_fp
      assign fp_live[i] = fault_subtype[i] & ~arith_ctrl[AC_FP_LSB+i];
    end
  endgenerate

  always_comb begin
    suppress = 1'b0;
    if (fault_type == FT_ARITH && fault_subtype == SUB_INT_OVF) begin
      suppress = arith_ctrl[AC_INT_OVF];
    end else if (fault_type == FT_FLOAT) begin
      // reserved-encoding has no mask, so it always passes
      suppress = (fp_live == '0) && !fault_subtype[FP_MASKED_N];
    end else if (fault_type == FT_TRACE) begin
      suppress = !trace_en || ((fault_subtype[7:1] & trace_modes[7:1]) == 7'h00);
    end
  end

endmodule

// [hdl/entry_decoder.sv]
// decodes the first word of a fault-table or procedure-table entry
`timescale 1ns/1ps
module entry_decoder (
  input  wire logic [31:0] word,
  output logic             is_local,
  output logic             is_system,
  output logic             is_bad,
  output logic [31:0]      target,
  output logic [29:0]      proc_num
);
  import fault_dispatch_pkg::*;

  assign is_local  = word[1:0] == ET_LOCAL;
  assign is_system = word[1:0] == ET_SYSTEM;
  assign is_bad    = !is_local && !is_system;
  // handlers are word aligned, the type bits are not part of the address
  assign target    = {word[31:2], 2'b00};
  assign proc_num  = word[31:2];

endmodule

// [hdl/fault_dispatch_unit.sv]
// fault dispatch unit: table lookup, handler call, interrupt ordering, return control
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module fault_dispatch_unit (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             irq,
  input  wire logic                        fault_req,
  input  wire logic [7:0]                  fault_type,
  input  wire logic [7:0]                  fault_subtype,
  input  wire logic [31:0]                 fault_ret_addr,
  input  wire logic                        fault_user_mode,
  input  wire logic                        fault_suspended,
  output logic                             fault_ready,
  output logic                             sync_imprecise,
  output logic                             mem_req,
  output logic [31:0]                      mem_addr,
  input  wire logic [31:0]                 mem_rdata,
  input  wire logic                        mem_ack,
  input  wire logic                        int_req,
  output logic                             int_service,
  output logic                             int_fault_in_record,
  input  wire logic                        int_done,
  output logic                             dispatch_valid,
  output logic [31:0]                      handler_addr,
  output fault_dispatch_pkg::call_kind_t   call_kind,
  output logic                             enter_supervisor,
  output logic                             stack_switch,
  output logic [31:0]                      new_sp,
  output logic                             records_local,
  output logic                             resume_flag,
  output logic                             rip_write,
  output logic [31:0]                      rip_data,
  input  wire logic                        ret_req,
  input  wire logic                        ret_supervisor,
  output logic                             ret_valid,
  output logic                             restore_proc_ctrl,
  output logic                             use_resumption,
  output logic [31:0]                      resume_addr
);
  import fault_dispatch_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RD_W0, S_RD_W1, S_RD_SPT, S_RD_SSP, S_INT_WAIT, S_DISPATCH} state_t;

  typedef struct packed {
    state_t             st;
    state_t             after;
    logic [31:0]        ft_base;
    logic [31:0]        spt_base;
    logic [15:0]        arith;
    logic [7:0]         trace_modes;
    logic               trace_en;
    logic               policy;
    logic [STAT_W-1:0]  status;
    logic [STAT_W-1:0]  mask;
    logic [7:0]         ftype;
    logic               user_mode;
    logic               suspended;
    logic               served;
    logic [31:0]        saved_return_address_slot;
    logic [31:0]        maddr;
    logic [31:0]        handler;
    logic [31:0]        sp;
    logic [29:0]        pnum;
    call_kind_t         kind;
    logic               last_susp;
    logic               disp_v;
    logic               int_srv;
    logic               int_rec;
    logic               ret_v;
    logic               restore;
    logic               use_res;
    logic [31:0]        res_addr;
    logic [31:0]        rdata;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;

  logic        suppress;
  logic        ent_local;
  logic        ent_system;
  logic        ent_bad;
  logic [31:0] ent_target;
  logic [29:0] ent_pnum;
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;

  fault_filter u_filter (
    .fault_type    (fault_type),
    .fault_subtype (fault_subtype),
    .arith_ctrl    (r_reg.arith),
    .trace_modes   (r_reg.trace_modes),
    .trace_en      (r_reg.trace_en),
    .suppress      (suppress)
  );

  entry_decoder u_decode (
    .word      (mem_rdata),
    .is_local  (ent_local),
    .is_system (ent_system),
    .is_bad    (ent_bad),
    .target    (ent_target),
    .proc_num  (ent_pnum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  always_comb begin
    unique case (paddr)
      OFF_FT_BASE, OFF_SPT_BASE, OFF_ARITH, OFF_TRACE,
      OFF_PROC, OFF_STATUS, OFF_MASK, OFF_STATE: mapped = 1'b1;
      default:                                   mapped = 1'b0;
    endcase
  end

  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next          = r_reg;
    r_next.disp_v   = 1'b0;
    r_next.int_srv  = 1'b0;
    r_next.ret_v    = 1'b0;
    stat_set        = '0;
    stat_clr        = '0;

    if (wr_en) begin
      unique case (paddr)
        OFF_FT_BASE:  r_next.ft_base  = pwdata;
        OFF_SPT_BASE: r_next.spt_base = pwdata;
        OFF_ARITH:    r_next.arith    = pwdata[15:0];
        OFF_TRACE:    r_next.trace_modes = pwdata[7:0];
        OFF_PROC: begin
          r_next.trace_en = pwdata[PC_TRACE_EN];
          r_next.policy   = pwdata[PC_POLICY];
        end
        OFF_STATUS:   stat_clr        = pwdata[STAT_W-1:0];
        OFF_MASK:     r_next.mask     = pwdata[STAT_W-1:0];
        default: ;
      endcase
    end

    if (rd_setup) begin
      unique case (paddr)
        OFF_FT_BASE:  r_next.rdata = r_reg.ft_base;
        OFF_SPT_BASE: r_next.rdata = r_reg.spt_base;
        OFF_ARITH:    r_next.rdata = {16'h0000, r_reg.arith};
        OFF_TRACE:    r_next.rdata = {24'h000000, r_reg.trace_modes};
        OFF_PROC:     r_next.rdata = {30'h00000000, r_reg.policy, r_reg.trace_en};
        OFF_STATUS:   r_next.rdata = {28'h0000000, r_reg.status};
        OFF_MASK:     r_next.rdata = {28'h0000000, r_reg.mask};
        OFF_STATE:    r_next.rdata = {8'h00, r_reg.ftype, 6'h00, r_reg.kind, 5'h00, r_reg.st};
        default:      r_next.rdata = 32'h0000_0000;
      endcase
    end

    unique case (r_reg.st)
      S_IDLE: begin
        if (ret_req) begin
          r_next.ret_v    = 1'b1;
          r_next.res_addr = r_reg.saved_return_address_slot;
          r_next.restore  = ret_supervisor;
          // only a supervisor-entered handler returning in supervisor resumes the instruction
          r_next.use_res  = ret_supervisor && r_reg.kind == CALL_SUPER && r_reg.last_susp;
          stat_set[ST_RETURN] = 1'b1;
        end else if (fault_req) begin
          if (suppress) begin
            stat_set[ST_SUPPRESS] = 1'b1;
          end else begin
            r_next.ftype     = fault_type;
            r_next.saved_return_address_slot       = fault_ret_addr;
            r_next.user_mode = fault_user_mode;
            r_next.suspended = fault_suspended;
            r_next.served    = 1'b0;
            r_next.maddr     = r_reg.ft_base + ({24'h000000, fault_type} << ENTRY_SHIFT);
            r_next.st        = S_RD_W0;
            if (int_req && !r_reg.policy) begin
              r_next.int_srv = 1'b1;
              r_next.int_rec = 1'b1;
              r_next.served  = 1'b1;
              r_next.after   = S_RD_W0;
              r_next.st      = S_INT_WAIT;
            end
          end
        end
      end
      S_RD_W0: begin
        if (mem_ack) begin
          r_next.handler = ent_target;
          r_next.pnum    = ent_pnum;
          r_next.maddr   = r_reg.maddr + WORD_BYTES;
          if (ent_bad) begin
            stat_set[ST_BAD_ENTRY] = 1'b1;
            r_next.st = S_IDLE;
          end else begin
            r_next.kind = ent_local ? CALL_LOCAL : CALL_LOCAL_TABLE;
            r_next.st   = S_RD_W1;
          end
        end
      end
      S_RD_W1: begin
        // second word is reserved for local entries and unused by system entries
        if (mem_ack) begin
          if (r_reg.kind == CALL_LOCAL) begin
            r_next.st = S_DISPATCH;
          end else begin
            r_next.maddr = r_reg.spt_base + SPT_ENTRY_OFF + {r_reg.pnum, 2'b00};
            r_next.st    = S_RD_SPT;
          end
          if (int_req && !r_reg.policy && !r_reg.served) begin
            r_next.int_srv = 1'b1;
            r_next.int_rec = 1'b1;
            r_next.served  = 1'b1;
            r_next.after   = r_next.st;
            r_next.st      = S_INT_WAIT;
          end
        end
      end
      S_RD_SPT: begin
        if (mem_ack) begin
          r_next.handler = ent_target;
          if (mem_rdata[1:0] == SPT_SUPER) begin
            r_next.kind = CALL_SUPER;
            if (r_reg.user_mode) begin
              r_next.maddr = r_reg.spt_base + SPT_SSP_OFF;
              r_next.st    = S_RD_SSP;
            end else begin
              r_next.st    = S_DISPATCH;
            end
          end else begin
            r_next.kind = CALL_LOCAL_TABLE;
            r_next.st   = S_DISPATCH;
          end
        end
      end
      S_RD_SSP: begin
        if (mem_ack) begin
          r_next.sp = mem_rdata;
          r_next.st = S_DISPATCH;
        end
      end
      S_INT_WAIT: begin
        if (int_done) begin
          r_next.st = r_reg.after;
        end
      end
      S_DISPATCH: begin
        if (int_req && r_reg.policy && !r_reg.served) begin
          r_next.int_srv = 1'b1;
          r_next.int_rec = 1'b0;
          r_next.served  = 1'b1;
          r_next.after   = S_DISPATCH;
          r_next.st      = S_INT_WAIT;
        end else begin
          r_next.disp_v    = 1'b1;
          r_next.last_susp = r_reg.suspended;
          stat_set[ST_DISPATCH] = 1'b1;
          r_next.st        = S_IDLE;
        end
      end
    endcase

    // a new event wins over a clear in the same cycle
    r_next.status = (r_reg.status & ~stat_clr) | stat_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg             <= '0;
      r_reg.st          <= S_IDLE;
      r_reg.after       <= S_IDLE;
      r_reg.kind        <= CALL_LOCAL;
      r_reg.arith       <= ARITH_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata              = r_reg.rdata;
  assign irq                 = |(r_reg.status & r_reg.mask);
  assign fault_ready         = r_reg.st == S_IDLE && !ret_req;
  assign sync_imprecise      = r_reg.arith[AC_NIF];
  assign mem_req             = r_reg.st == S_RD_W0 || r_reg.st == S_RD_W1 ||
                               r_reg.st == S_RD_SPT || r_reg.st == S_RD_SSP;
  assign mem_addr            = r_reg.maddr;
  assign int_service         = r_reg.int_srv;
  assign int_fault_in_record = r_reg.int_rec;
  assign dispatch_valid      = r_reg.disp_v;
  assign handler_addr        = r_reg.handler;
  assign call_kind           = r_reg.kind;
  assign enter_supervisor    = r_reg.kind == CALL_SUPER;
  assign stack_switch        = r_reg.kind == CALL_SUPER && r_reg.user_mode;
  assign new_sp              = r_reg.sp;
  assign records_local       = r_reg.user_mode;
  assign resume_flag         = r_reg.last_susp;
  assign rip_write           = r_reg.disp_v;
  assign rip_data            = r_reg.saved_return_address_slot;
  assign ret_valid           = r_reg.ret_v;
  assign restore_proc_ctrl   = r_reg.restore;
  assign use_resumption      = r_reg.use_res;
  assign resume_addr         = r_reg.res_addr;

endmodule

// [bench/fault_mem_model.sv]
// behavioural memory holding the fault table and system procedure table
`timescale 1ns/1ps
module fault_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic [31:0]      mem_rdata,
  output logic             mem_ack
);
  logic [31:0] mem [logic [31:0]];
  int          lat = 0;
  int          cnt;
  initial begin
    mem[32'h0000_1008] = 32'h0000_4200;
    mem[32'h0000_1010] = 32'h0000_4000;
    mem[32'h0000_1020] = 32'h0000_4100;
    mem[32'h0000_1028] = 32'h0000_000E;
    mem[32'h0000_1040] = 32'h0000_0012;
    mem[32'h0000_1048] = 32'h0000_0001;
    mem[32'h0000_1050] = 32'h0000_0003;
    mem[32'h0000_200C] = 32'h0000_8000;
    mem[32'h0000_203C] = 32'h0000_5000;
    mem[32'h0000_2040] = 32'h0000_6002;
  end
  ////////////////////////////////////////////////////////////////
  // unwritten words, incl. second words of local entries, read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      cnt <= 0;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
      cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) cnt <= cnt + 1;
    end
  end
endmodule

// [bench/fault_dispatch_unit_asserts.sv]
// port assertions for the fault dispatch unit
`timescale 1ns/1ps
module fault_dispatch_unit_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        sync_imprecise,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        int_service,
  input wire logic        dispatch_valid,
  input wire logic        rip_write,
  input wire logic [1:0]  call_kind,
  input wire logic        enter_supervisor,
  input wire logic        stack_switch,
  input wire logic        records_local,
  input wire logic        fault_req,
  input wire logic        fault_ready,
  input wire logic        ret_req,
  input wire logic        ret_supervisor,
  input wire logic        ret_valid,
  input wire logic        restore_proc_ctrl,
  input wire logic        use_resumption
);
  import fault_dispatch_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_wait; mem_req && !mem_ack; endsequence
  sequence s_rd_same; mem_req && $stable(mem_addr); endsequence
  property p_unmapped; psel && penable && paddr > OFF_STATE |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_nif; psel && penable && pwrite && paddr == OFF_ARITH |=> sync_imprecise == $past(pwdata[AC_NIF]); endproperty
  a_nif: assert property (p_nif) else $error("imprecise sync flag wrong");
  property p_rd_hold; s_rd_wait |=> s_rd_same; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("table read dropped early");
  property p_disp; dispatch_valid |-> rip_write ##1 !dispatch_valid; endproperty
  a_disp: assert property (p_disp) else $error("dispatch pulse or return slot write wrong");
  property p_super; dispatch_valid && stack_switch |-> call_kind == CALL_SUPER && enter_supervisor && records_local; endproperty
  a_super: assert property (p_super) else $error("stack switch without supervisor entry");
  property p_local; dispatch_valid && call_kind != CALL_SUPER |-> !enter_supervisor && !stack_switch; endproperty
  a_local: assert property (p_local) else $error("local handler entered supervisor");
  property p_ret; ret_req && $past(fault_ready) && !$past(fault_req) |=> ret_valid && restore_proc_ctrl == $past(ret_supervisor); endproperty
  a_ret: assert property (p_ret) else $error("return control wrong");
  property p_nores; ret_valid && !restore_proc_ctrl |-> !use_resumption; endproperty
  a_nores: assert property (p_nores) else $error("resumption used without supervisor");
  property p_int; int_service |=> !int_service && !dispatch_valid; endproperty
  a_int: assert property (p_int) else $error("interrupt service not waited for");
endmodule
bind fault_dispatch_unit fault_dispatch_unit_asserts fault_dispatch_unit_asserts_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .sync_imprecise, .mem_req, .mem_addr, .mem_ack, .int_service,
  .dispatch_valid, .rip_write, .call_kind(call_kind), .enter_supervisor, .stack_switch, .records_local,
  .fault_req, .fault_ready, .ret_req, .ret_supervisor, .ret_valid, .restore_proc_ctrl, .use_resumption);

// [bench/fault_dispatch_unit_bench.sv]
// self-checking bench for the fault dispatch unit
`timescale 1ns/1ps
module fault_dispatch_unit_bench;
  import fault_dispatch_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fault_req, fault_user_mode, fault_suspended;
  logic fault_ready, sync_imprecise, mem_req, mem_ack, int_req, int_service, int_fault_in_record, int_done;
  logic dispatch_valid, enter_supervisor, stack_switch, records_local, resume_flag, rip_write, ret_req;
  logic ret_supervisor, ret_valid, restore_proc_ctrl, use_resumption, d_w, i_rec;
  logic [11:0] paddr;
  logic [7:0]  fault_type, fault_subtype;
  logic [31:0] pwdata, prdata, fault_ret_addr, mem_addr, mem_rdata, handler_addr, new_sp, rip_data, resume_addr;
  logic [31:0] ra, d_h, d_rip, d_sp;
  logic [3:0]  d_m;
  call_kind_t  call_kind, d_k;
  int          n_mismatch, n_checks, n_disp, n_int;
  time         t_int, t_ack;
  fault_dispatch_unit fault_dispatch_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .fault_req, .fault_type, .fault_subtype, .fault_ret_addr, .fault_user_mode,
    .fault_suspended, .fault_ready, .sync_imprecise, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .int_req,
    .int_service, .int_fault_in_record, .int_done, .dispatch_valid, .handler_addr, .call_kind, .enter_supervisor,
    .stack_switch, .new_sp, .records_local, .resume_flag, .rip_write, .rip_data, .ret_req, .ret_supervisor,
    .ret_valid, .restore_proc_ctrl, .use_resumption, .resume_addr);
  fault_mem_model fault_mem_model_i (.pclk, .presetn, .mem_req, .mem_addr, .mem_rdata, .mem_ack);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    int_done <= int_service;
    if (mem_ack) t_ack = $time;
    if (int_service) begin
      n_int++;
      t_int = $time;
      i_rec = int_fault_in_record;
      int_req <= 1'b0;
    end
    if (dispatch_valid) begin
      n_disp++;
      {d_h, d_k, d_w, d_rip, d_sp} = {handler_addr, call_kind, rip_write, rip_data, new_sp};
      d_m = {enter_supervisor, stack_switch, records_local, resume_flag};
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk({nm, " err"}, {31'h0, e}, {31'h0, xe});
  endtask
  task flt(input logic [7:0] t, input logic [7:0] s, input logic um, input logic su, input int nd);
    int n0;
    n0 = n_disp;
    ra = {16'hA000, t, s};
    @(posedge pclk);
    {fault_type, fault_subtype, fault_ret_addr, fault_user_mode, fault_suspended} <= {t, s, ra, um, su};
    fault_req <= 1'b1;
    @(posedge pclk);
    fault_req <= 1'b0;
    do @(posedge pclk); while (fault_ready !== 1'b1);
    repeat (2) @(posedge pclk);
    chk("dispatches", 32'(n_disp - n0), 32'(nd));
  endtask
  task dchk(input call_kind_t k, input logic [31:0] h, input logic [3:0] m);
    chk("kind", 32'(d_k), 32'(k));
    chk("handler", d_h, h);
    chk("rip", {d_rip[31:1], d_w}, {ra[31:1], 1'b1});
    chk("modes", {28'h0, d_m}, {28'h0, m});
    if (m[2]) chk("stack", d_sp, 32'h0000_8000);
  endtask
  task ret(input logic sv, input logic ru);
    @(posedge pclk);
    {ret_req, ret_supervisor} <= {1'b1, sv};
    @(posedge pclk);
    ret_req <= 1'b0;
    do @(posedge pclk); while (ret_valid !== 1'b1);
    chk("restore", {31'h0, restore_proc_ctrl}, {31'h0, sv});
    chk("resumption", {31'h0, use_resumption}, {31'h0, ru});
    chk("resume addr", resume_addr, ra);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fault_req, fault_type, fault_subtype} = '0;
    {fault_ret_addr, fault_user_mode, fault_suspended, int_req, int_done, ret_req, ret_supervisor} = '0;
    {n_mismatch, n_checks, n_disp, n_int} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("status rst", OFF_STATUS, 32'h0, 1'b0);
    rd("arith rst", OFF_ARITH, 32'h0, 1'b0);
    rd("unmapped", 12'h100, 32'h0, 1'b1);
    wr(OFF_FT_BASE, 32'h0000_1000);
    wr(OFF_SPT_BASE, 32'h0000_2000);
    wr(OFF_MASK, 32'h0000_000F);
    wr(OFF_ARITH, 32'h0000_8005);
    rd("arith", OFF_ARITH, 32'h0000_8005, 1'b0);
    chk("no imprecise", {31'h0, sync_imprecise}, 32'h1);
    flt(FT_ARITH, SUB_INT_OVF, 1'b0, 1'b0, 0);
    flt(FT_FLOAT, 8'h02, 1'b0, 1'b0, 0);
    flt(FT_TRACE, 8'h02, 1'b0, 1'b0, 0);
    rd("status supp", OFF_STATUS, 32'h2, 1'b0);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(OFF_STATUS, 32'h2);
    @(posedge pclk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    flt(FT_FLOAT, 8'h01, 1'b0, 1'b0, 1);
    dchk(CALL_LOCAL, 32'h0000_4100, 4'b0000);
    wr(OFF_PROC, 32'h1);
    wr(OFF_TRACE, 32'h2);
    flt(FT_TRACE, 8'h04, 1'b0, 1'b0, 0);
    flt(FT_TRACE, 8'h02, 1'b0, 1'b0, 1);
    dchk(CALL_LOCAL, 32'h0000_4200, 4'b0000);
    wr(OFF_STATUS, 32'hF);
    flt(8'h02, 8'h01, 1'b0, 1'b1, 1);
    dchk(CALL_LOCAL, 32'h0000_4000, 4'b0001);
    ret(1'b0, 1'b0);
    rd("status ret", OFF_STATUS, 32'h9, 1'b0);
    wr(OFF_STATUS, 32'h9);
    rd("status w1c", OFF_STATUS, 32'h0, 1'b0);
    fault_mem_model_i.lat = 2;
    flt(8'h05, 8'h01, 1'b0, 1'b0, 1);
    dchk(CALL_LOCAL_TABLE, 32'h0000_5000, 4'b0000);
    fault_mem_model_i.lat = 0;
    flt(8'h08, 8'h01, 1'b1, 1'b1, 1);
    dchk(CALL_SUPER, 32'h0000_6000, 4'b1111);
    ret(1'b1, 1'b1);
    flt(8'h08, 8'h02, 1'b0, 1'b0, 1);
    dchk(CALL_SUPER, 32'h0000_6000, 4'b1000);
    ret(1'b1, 1'b0);
    rd("state", OFF_STATE, 32'h0008_0200, 1'b0);
    wr(OFF_STATUS, 32'hF);
    flt(8'h09, 8'h01, 1'b0, 1'b0, 0);
    flt(8'h0A, 8'h01, 1'b0, 1'b0, 0);
    rd("status bad", OFF_STATUS, 32'h4, 1'b0);
    for (int p = 0; p < 2; p++) begin
      wr(OFF_PROC, 32'(p * 2));
      @(posedge pclk);
      int_req <= 1'b1;
      flt(8'h02, 8'h03, 1'b0, 1'b0, 1);
      chk("int count", 32'(n_int), 32'(p + 1));
      chk("int record", {31'h0, i_rec}, {31'h0, p == 0});
      chk("int order", {31'h0, t_int > t_ack}, {31'h0, p == 1});
    end
    test_done;
  end
endmodule
